// ===== rtl/datapath_pkg.sv
// Constants shared by the terminal processor register datapath
package datapath_pkg;
	localparam int ACC_W = 8;
	localparam int LINE_W = 6;
	localparam int FLAG_W = 3;
	localparam int PC_W = 12;
	localparam int MEM_W = 16;
	localparam int AUX_W = 12;
	localparam int LINE_AUX_LSB = 6;
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_NEG = 2;
	localparam int MEM_LOW_TOP = 7;
	localparam int MEM_MID_TOP = 11;
	localparam int PC_LOW_TOP = 8;
	localparam int PC_BIT9 = 9;
	localparam int MEM_AUX_LOW_TOP = 8;
	localparam int INS_CARRY_BIT = 8;
	localparam int INS_ZERO_BIT = 9;
	localparam int INS_QUAL0_BIT = 0;
	localparam int INS_QUAL1_BIT = 1;
	localparam int INS_COMMON_A_BIT = 2;
	localparam int INS_COMMON_B_BIT = 13;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [5:0] LINE_RESET = 6'h00;
	localparam logic [2:0] FLAG_RESET = 3'h0;
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam logic [15:0] MEM_RESET = 16'h0000;
	localparam logic [11:0] PC_STEP = 12'h002;
endpackage : datapath_pkg

// ===== rtl/terminal_cpu_register_datapath.sv
// Register datapath of the terminal processor: registers, bus drivers, tests
`timescale 1ns/1ps

// Overview of operation
// - Line register loads from aux result upper six or accumulator; separate bus enable
// - Accumulator is 8 bits, set from adder bit, cleared from its inverse
// - AND-disable gates all sets, OR-disable gates all clears
// - Low nibble and high nibble of accumulator load on separate strobes
// - Accumulator feeds adder steering, line steering, and inverted output bus
// - Transfer enable puts accumulator bits 0-3 on byte bus bits 4-7
// - Flags: bit0 carry, bit1 zero result, bit2 byte result msb
// - Zero flag comes from all twelve aux adder bits or all eight byte adder bits being zero
// - Three drivers put the flags onto the memory data bus
// - Program counter is 12 bits, bit0 zero, loads bits 1-11 from aux result
// - Program counter advances through aux unit adding two
// - Counter output to aux bus uses three enables: bits 0-8, 9, 10-11
// - Top sector flag when counter bits 9, 10 and 11 all set
// - Test true when instruction bit 8 set and no carry stored
// - Zero flag test qualified by instruction bit 9; terms combined into one output
// - Negative and odd tests qualified by bits 0,1 and common term of bits 2,13
// - Accumulator to memory bus goes low or high byte by byte select
// - Memory register low or high byte, true or inverted, onto byte bus
// - Memory register 16 bits loaded by three strobes: 0-7, 8-11, 12-15
// - Memory register to aux bus: enable bits 0-8, enable bits 9-11
// - XOR enable drives accumulator xor memory low byte onto byte bus
// - Byte bus active high; memory data and aux buses active low
module terminal_cpu_register_datapath (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] byte_adder_sum,
	input wire logic byte_adder_carry,
	input wire logic [11:0] aux_adder_sum,
	input wire logic aux_adder_carry,
	input wire logic [11:0] aux_arith_result_reg,
	input wire logic [15:0] memory_data_bus_in_n,
	input wire logic flags_strobe,
	input wire logic flags_from_aux,
	input wire logic line_strobe,
	input wire logic line_from_aux_select,
	input wire logic line_from_accum_select,
	input wire logic line_to_bus_enable,
	input wire logic accum_or_disable,
	input wire logic accum_and_disable,
	input wire logic accum_low_strobe,
	input wire logic accum_high_strobe,
	input wire logic accum_nibble_to_bus_en,
	input wire logic pc_strobe,
	input wire logic pc_low_to_aux_en,
	input wire logic pc_bit9_to_aux_en,
	input wire logic pc_top_to_aux_en,
	input wire logic flags_to_membus_en,
	input wire logic accum_to_membus_ctrl,
	input wire logic memreg_true_to_bus_ctrl,
	input wire logic memreg_inv_to_bus_ctrl,
	input wire logic memreg_low_to_aux_en,
	input wire logic memreg_top_to_aux_en,
	input wire logic memreg_byte0_strobe,
	input wire logic memreg_mid_strobe,
	input wire logic memreg_top_strobe,
	input wire logic xor_unit_enable,
	input wire logic opcode_top_bit,
	input wire logic address_lsb,
	output logic [7:0] byte_arith_bus,
	output logic [15:0] memory_data_bus_n,
	output logic [11:0] aux_arith_bus_n,
	output logic [7:0] accum_out_bus_n,
	output logic [7:0] accum_to_adder,
	output logic [7:0] accumulator_reg,
	output logic [5:0] line_position_reg,
	output logic [2:0] condition_flags_reg,
	output logic [11:0] program_counter_reg,
	output logic [15:0] memory_data_reg,
	output logic top_sector_flag,
	output logic test_condition_out
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] acc;
		logic [5:0] line;
		logic [2:0] flags;
		logic [11:0] pc;
		logic [15:0] mem;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic byte_select_term;
	logic accum_to_high_byte_en;
	logic accum_to_low_byte_en;
	logic high_byte_to_bus_en;
	logic low_byte_to_bus_en;
	logic high_byte_inv_to_bus_en;
	logic low_byte_inv_to_bus_en;
	logic [7:0] acc_set;
	logic [7:0] acc_clr;
	logic [7:0] acc_jk;
	logic [15:0] memory_data_bus;
	logic [11:0] aux_arith_bus;
	logic [7:0] mem_byte;
	logic aux_zero;
	logic common_term;

	// Byte select picks odd/even byte of a memory word
	function automatic logic pick(input logic ctrl, input logic high, input logic sel);
		pick = ctrl & (high ? sel : ~sel);
	endfunction : pick

	// ==========================================================
	// Byte enable decoding
	assign byte_select_term = address_lsb ^ opcode_top_bit;
	assign accum_to_high_byte_en = pick(accum_to_membus_ctrl, 1'b1, byte_select_term);
	assign accum_to_low_byte_en = pick(accum_to_membus_ctrl, 1'b0, byte_select_term);
	assign high_byte_to_bus_en = pick(memreg_true_to_bus_ctrl, 1'b1, byte_select_term);
	assign low_byte_to_bus_en = pick(memreg_true_to_bus_ctrl, 1'b0, byte_select_term);
	assign high_byte_inv_to_bus_en = pick(memreg_inv_to_bus_ctrl, 1'b1, byte_select_term);
	assign low_byte_inv_to_bus_en = pick(memreg_inv_to_bus_ctrl, 1'b0, byte_select_term);

	// ==========================================================
	// Accumulator J-K inputs
	generate
		for (genvar i = 0; i < datapath_pkg::ACC_W; i++)
		begin : g_acc
			assign acc_set[i] = byte_adder_sum[i] & ~accum_and_disable;
			assign acc_clr[i] = ~byte_adder_sum[i] & ~accum_or_disable;
			// J-K behaviour: set wins only with data one, clear only with data zero
			assign acc_jk[i] = acc_set[i] ? 1'b1 : (acc_clr[i] ? 1'b0 : state_reg.acc[i]);
		end
	endgenerate

	// ==========================================================
	// Shared buses, zero when no source is enabled
	always_comb
	begin
		byte_arith_bus = 8'h00;
		mem_byte = byte_select_term ? state_reg.mem[15:8] : state_reg.mem[7:0];
		// Sources OR together; a sequencer overlap shows as merged data
		if (accum_nibble_to_bus_en)
		begin
			byte_arith_bus = byte_arith_bus | {state_reg.acc[3:0], 4'h0};
		end
		if (line_to_bus_enable)
		begin
			byte_arith_bus = byte_arith_bus | {2'h0, state_reg.line};
		end
		if (high_byte_to_bus_en | low_byte_to_bus_en)
		begin
			byte_arith_bus = byte_arith_bus | mem_byte;
		end
		if (high_byte_inv_to_bus_en | low_byte_inv_to_bus_en)
		begin
			byte_arith_bus = byte_arith_bus | ~mem_byte;
		end
		if (xor_unit_enable)
		begin
			byte_arith_bus = byte_arith_bus | (state_reg.acc ^ state_reg.mem[7:0]);
		end
	end

	always_comb
	begin
		memory_data_bus = 16'h0000;
		if (accum_to_low_byte_en)
		begin
			memory_data_bus[7:0] = state_reg.acc;
		end
		if (accum_to_high_byte_en)
		begin
			memory_data_bus[15:8] = state_reg.acc;
		end
		if (flags_to_membus_en)
		begin
			memory_data_bus[2:0] = memory_data_bus[2:0] | state_reg.flags;
		end
	end

	always_comb
	begin
		aux_arith_bus = 12'h000;
		if (pc_low_to_aux_en)
		begin
			aux_arith_bus[8:0] = state_reg.pc[8:0];
		end
		if (pc_bit9_to_aux_en)
		begin
			aux_arith_bus[9] = state_reg.pc[9];
		end
		if (pc_top_to_aux_en)
		begin
			aux_arith_bus[11:10] = state_reg.pc[11:10];
		end
		if (memreg_low_to_aux_en)
		begin
			aux_arith_bus[8:0] = aux_arith_bus[8:0] | state_reg.mem[8:0];
		end
		if (memreg_top_to_aux_en)
		begin
			aux_arith_bus[11:9] = aux_arith_bus[11:9] | state_reg.mem[11:9];
		end
	end

	// Active-low buses toward memory and aux unit
	assign memory_data_bus_n = ~memory_data_bus;
	assign aux_arith_bus_n = ~aux_arith_bus;
	assign accum_out_bus_n = ~state_reg.acc;
	assign accum_to_adder = state_reg.acc;

	// ==========================================================
	// Flags and tests
	assign aux_zero = (aux_adder_sum == 12'h000);
	assign common_term = memory_data_reg[datapath_pkg::INS_COMMON_A_BIT]
		& memory_data_reg[datapath_pkg::INS_COMMON_B_BIT];
	assign test_condition_out =
		(memory_data_reg[datapath_pkg::INS_CARRY_BIT]
			& ~condition_flags_reg[datapath_pkg::FLAG_CARRY])
		| (memory_data_reg[datapath_pkg::INS_ZERO_BIT]
			& condition_flags_reg[datapath_pkg::FLAG_ZERO])
		| (memory_data_reg[datapath_pkg::INS_QUAL0_BIT]
			& memory_data_reg[datapath_pkg::INS_QUAL1_BIT] & common_term
			& condition_flags_reg[datapath_pkg::FLAG_NEG])
		| (memory_data_reg[datapath_pkg::INS_QUAL0_BIT]
			& memory_data_reg[datapath_pkg::INS_QUAL1_BIT] & common_term
			& accumulator_reg[0]);
	assign top_sector_flag = &program_counter_reg[11:9];

	// ==========================================================
	// Next state
	always_comb
	begin
		state_next = state_reg;
		if (accum_low_strobe)
		begin
			state_next.acc[3:0] = acc_jk[3:0];
		end
		if (accum_high_strobe)
		begin
			state_next.acc[7:4] = acc_jk[7:4];
		end
		if (line_strobe)
		begin
			state_next.line = ({6{line_from_aux_select}} & aux_arith_result_reg[11:6])
				| ({6{line_from_accum_select}} & state_reg.acc[5:0]);
		end
		if (flags_strobe)
		begin
			state_next.flags[datapath_pkg::FLAG_CARRY] =
				flags_from_aux ? aux_adder_carry : byte_adder_carry;
			state_next.flags[datapath_pkg::FLAG_ZERO] =
				flags_from_aux ? aux_zero : (byte_adder_sum == 8'h00);
			state_next.flags[datapath_pkg::FLAG_NEG] =
				flags_from_aux ? state_reg.flags[datapath_pkg::FLAG_NEG]
				: byte_adder_sum[7];
		end
		if (pc_strobe)
		begin
			state_next.pc = {aux_arith_result_reg[11:1], 1'b0};
		end
		if (memreg_byte0_strobe)
		begin
			state_next.mem[7:0] = ~memory_data_bus_in_n[7:0];
		end
		if (memreg_mid_strobe)
		begin
			state_next.mem[11:8] = ~memory_data_bus_in_n[11:8];
		end
		if (memreg_top_strobe)
		begin
			state_next.mem[15:12] = ~memory_data_bus_in_n[15:12];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '{acc: datapath_pkg::ACC_RESET, line: datapath_pkg::LINE_RESET,
				flags: datapath_pkg::FLAG_RESET, pc: datapath_pkg::PC_RESET,
				mem: datapath_pkg::MEM_RESET};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign accumulator_reg = state_reg.acc;
	assign line_position_reg = state_reg.line;
	assign condition_flags_reg = state_reg.flags;
	assign program_counter_reg = state_reg.pc;
	assign memory_data_reg = state_reg.mem;

	// ==========================================================
	// Checks
	sequence pc_load_s;
		pc_strobe && rst_n;
	endsequence

	pc_bit0_a: assert property (@(posedge clk) disable iff (!rst_n)
		program_counter_reg[0] == 1'b0) else $error("pc bit0 not zero");
	pc_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		pc_load_s |=> program_counter_reg[11:1] == $past(aux_arith_result_reg[11:1]))
		else $error("pc load wrong");
	top_sector_a: assert property (@(posedge clk) disable iff (!rst_n)
		top_sector_flag == (program_counter_reg[11:9] == 3'h7))
		else $error("top sector wrong");
	acc_or_a: assert property (@(posedge clk) disable iff (!rst_n)
		accum_low_strobe && accum_high_strobe && accum_or_disable && !accum_and_disable
		|=> accumulator_reg == ($past(accumulator_reg) | $past(byte_adder_sum)))
		else $error("or merge wrong");
	acc_and_a: assert property (@(posedge clk) disable iff (!rst_n)
		accum_low_strobe && accum_high_strobe && accum_and_disable && !accum_or_disable
		|=> accumulator_reg == ($past(accumulator_reg) & $past(byte_adder_sum)))
		else $error("and merge wrong");
	acc_nibble_a: assert property (@(posedge clk) disable iff (!rst_n)
		accum_low_strobe && !accum_high_strobe
		|=> accumulator_reg[7:4] == $past(accumulator_reg[7:4]))
		else $error("high nibble moved");
	mem_top_a: assert property (@(posedge clk) disable iff (!rst_n)
		memreg_top_strobe |=> memory_data_reg[15:12] == ~$past(memory_data_bus_in_n[15:12]))
		else $error("mem top load wrong");
	xor_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		xor_unit_enable && !accum_nibble_to_bus_en && !line_to_bus_enable
		&& !memreg_true_to_bus_ctrl && !memreg_inv_to_bus_ctrl
		|-> byte_arith_bus == (accumulator_reg ^ memory_data_reg[7:0]))
		else $error("xor bus wrong");
	idle_aux_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(pc_low_to_aux_en | pc_bit9_to_aux_en | pc_top_to_aux_en
		| memreg_low_to_aux_en | memreg_top_to_aux_en) |-> aux_arith_bus_n == 12'hFFF)
		else $error("idle aux bus driven");
	// Flag is tied to the register, so check it against the value that was loaded
	top_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		pc_load_s ##0 (aux_arith_result_reg[11:9] == 3'h7) |=> top_sector_flag)
		else $error("top sector missed after load");
	zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		flags_strobe && flags_from_aux && (aux_adder_sum == 12'h000)
		|=> condition_flags_reg[datapath_pkg::FLAG_ZERO])
		else $error("zero flag not set");
	acc_low_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		accum_high_strobe && !accum_low_strobe
		|=> accumulator_reg[3:0] == $past(accumulator_reg[3:0]))
		else $error("low nibble moved");
	mem_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		memreg_byte0_strobe |=> memory_data_reg[7:0] == ~$past(memory_data_bus_in_n[7:0]))
		else $error("mem low load wrong");
	nibble_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		accum_nibble_to_bus_en && !xor_unit_enable && !line_to_bus_enable
		&& !memreg_true_to_bus_ctrl && !memreg_inv_to_bus_ctrl
		|-> byte_arith_bus == {accumulator_reg[3:0], 4'h0})
		else $error("nibble bus wrong");
endmodule : terminal_cpu_register_datapath

// ===== sim/seq_model.sv
// Control sequencer model: turns one source code per shared bus into enables
`timescale 1ns/1ps
module seq_model (
	input wire logic [2:0] byte_src,
	input wire logic [1:0] aux_src,
	input wire logic [1:0] mem_src,
	output logic line_to_bus_enable,
	output logic accum_nibble_to_bus_en,
	output logic memreg_true_to_bus_ctrl,
	output logic memreg_inv_to_bus_ctrl,
	output logic xor_unit_enable,
	output logic pc_low_to_aux_en,
	output logic pc_bit9_to_aux_en,
	output logic pc_top_to_aux_en,
	output logic memreg_low_to_aux_en,
	output logic memreg_top_to_aux_en,
	output logic flags_to_membus_en,
	output logic accum_to_membus_ctrl
);
	// One code per bus, so two sources can never meet on a bus
	assign line_to_bus_enable = (byte_src == 3'h1);
	assign accum_nibble_to_bus_en = (byte_src == 3'h2);
	assign memreg_true_to_bus_ctrl = (byte_src == 3'h3);
	assign memreg_inv_to_bus_ctrl = (byte_src == 3'h4);
	assign xor_unit_enable = (byte_src == 3'h5);
	assign pc_low_to_aux_en = (aux_src == 2'h1) || (aux_src == 2'h3);
	assign pc_bit9_to_aux_en = (aux_src == 2'h1);
	assign pc_top_to_aux_en = (aux_src == 2'h1);
	assign memreg_low_to_aux_en = (aux_src == 2'h2);
	assign memreg_top_to_aux_en = (aux_src == 2'h2);
	assign flags_to_membus_en = (mem_src == 2'h1);
	assign accum_to_membus_ctrl = (mem_src == 2'h2);
endmodule : seq_model

// ===== sim/terminal_cpu_register_datapath_tb_top.sv
// Self-checking bench with reference model for the register datapath
`timescale 1ns/1ps
module terminal_cpu_register_datapath_tb_top;
	typedef struct {int id; logic [15:0] v;} note_s;
	logic clk, rst_n, byte_adder_carry, aux_adder_carry, flags_strobe, flags_from_aux;
	logic line_strobe, line_from_aux_select, line_from_accum_select, accum_or_disable;
	logic accum_and_disable, accum_low_strobe, accum_high_strobe, pc_strobe;
	logic memreg_byte0_strobe, memreg_mid_strobe, memreg_top_strobe, opcode_top_bit;
	logic address_lsb, line_to_bus_enable, accum_nibble_to_bus_en, memreg_true_to_bus_ctrl;
	logic memreg_inv_to_bus_ctrl, xor_unit_enable, pc_low_to_aux_en, pc_bit9_to_aux_en;
	logic pc_top_to_aux_en, memreg_low_to_aux_en, memreg_top_to_aux_en;
	logic flags_to_membus_en, accum_to_membus_ctrl, top_sector_flag, test_condition_out;
	logic [7:0] byte_adder_sum, byte_arith_bus, accum_out_bus_n, accum_to_adder;
	logic [7:0] accumulator_reg, m_acc;
	logic [11:0] aux_adder_sum, aux_arith_result_reg, aux_arith_bus_n, program_counter_reg;
	logic [11:0] m_pc;
	logic [15:0] memory_data_bus_in_n, memory_data_bus_n, memory_data_reg, m_mem;
	logic [5:0] line_position_reg, m_line;
	logic [2:0] condition_flags_reg, m_flg, byte_src;
	logic [1:0] aux_src, mem_src;
	note_s q[$];
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	string nm [12] = '{"acc", "mem", "pc", "flags", "line", "byte_bus", "mem_bus_n",
		"aux_bus_n", "out_bus_n", "to_adder", "top_sector", "test_cond"};

	terminal_cpu_register_datapath dut (.*);
	seq_model partner (.*);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================
	// Expectation queue and monitor
	// ==========================================
	task note(input int id, input logic [15:0] v);
		q.push_back('{id, v});
	endtask : note

	function automatic logic [15:0] seen(input int id);
		case (id)
			0: return {8'h00, accumulator_reg};
			1: return memory_data_reg;
			2: return {4'h0, program_counter_reg};
			3: return {13'h0000, condition_flags_reg};
			4: return {10'h000, line_position_reg};
			5: return {8'h00, byte_arith_bus};
			6: return memory_data_bus_n;
			7: return {4'hF, aux_arith_bus_n};
			8: return {8'h00, accum_out_bus_n};
			9: return {8'h00, accum_to_adder};
			10: return {15'h0000, top_sector_flag};
			default: return {15'h0000, test_condition_out};
		endcase
	endfunction : seen

	initial
	begin
		note_s n;
		logic [15:0] o;
		forever
		begin
			@(negedge clk);
			#5;
			while (q.size() > 0)
			begin
				n = q.pop_front();
				o = seen(n.id);
				num_checks++;
				if (o !== n.v)
				begin
					err_total++;
					$display("Error %s expected %h seen %h", nm[n.id], n.v, o);
				end
			end
		end
	end

	// ==========================================
	// Stimulus and reference model
	// ==========================================
	task cyc(input bit go, input bit chk);
		logic [7:0] j, k, nv, ml, eb;
		logic sel;
		begin
			{flags_strobe, flags_from_aux, line_strobe, line_from_aux_select,
				line_from_accum_select, accum_or_disable, accum_and_disable,
				accum_low_strobe, accum_high_strobe, pc_strobe, memreg_byte0_strobe,
				memreg_mid_strobe, memreg_top_strobe, opcode_top_bit,
				address_lsb} = go ? 15'($urandom) : 15'h0000;
			byte_src = go ? 3'($urandom % 6) : 3'h0;
			aux_src = go ? 2'($urandom) : 2'h0;
			mem_src = go ? 2'($urandom % 3) : 2'h0;
			// Zero sums forced often so the zero flag really gets set
			byte_adder_sum = ($urandom % 8 == 0) ? 8'h00 : 8'($urandom);
			aux_adder_sum = ($urandom % 4 == 0) ? 12'h000 : 12'($urandom);
			{byte_adder_carry, aux_adder_carry} = 2'($urandom);
			aux_arith_result_reg = 12'($urandom);
			memory_data_bus_in_n = 16'($urandom);
			sel = address_lsb ^ opcode_top_bit;
			ml = sel ? m_mem[15:8] : m_mem[7:0];
			case (byte_src)
				3'h1: eb = {2'h0, m_line};
				3'h2: eb = {m_acc[3:0], 4'h0};
				3'h3: eb = ml;
				3'h4: eb = ~ml;
				3'h5: eb = m_acc ^ m_mem[7:0];
				default: eb = 8'h00;
			endcase
			if (chk)
			begin
				note(0, {8'h00, m_acc});
				note(1, m_mem);
				note(2, {4'h0, m_pc});
				note(3, {13'h0000, m_flg});
				note(4, {10'h000, m_line});
				note(5, {8'h00, eb});
				note(6, mem_src == 2'h1 ? ~{13'h0000, m_flg} : mem_src == 2'h2 ?
					~(sel ? {m_acc, 8'h00} : {8'h00, m_acc}) : 16'hFFFF);
				note(7, {4'hF, aux_src == 2'h1 ? ~m_pc : aux_src == 2'h2 ? ~m_mem[11:0] :
					aux_src == 2'h3 ? ~{3'h0, m_pc[8:0]} : 12'hFFF});
				note(8, {8'h00, ~m_acc});
				note(9, {8'h00, m_acc});
				note(10, {15'h0000, &m_pc[11:9]});
				note(11, {15'h0000, (m_mem[8] & ~m_flg[0]) | (m_mem[9] & m_flg[1]) |
					(&{m_mem[0], m_mem[1], m_mem[2], m_mem[13]} &
					(m_flg[2] | m_acc[0]))});
			end
			if (!rst_n)
			begin
				{m_acc, m_mem, m_pc, m_flg, m_line} = 45'h0;
			end
			else
			begin
				j = byte_adder_sum & {8{~accum_and_disable}};
				k = ~byte_adder_sum & {8{~accum_or_disable}};
				nv = j | (m_acc & ~k);
				if (line_strobe)
					m_line = (line_from_aux_select ? aux_arith_result_reg[11:6] : 6'h00) |
						(line_from_accum_select ? m_acc[5:0] : 6'h00);
				if (accum_low_strobe)
					m_acc[3:0] = nv[3:0];
				if (accum_high_strobe)
					m_acc[7:4] = nv[7:4];
				if (memreg_byte0_strobe)
					m_mem[7:0] = ~memory_data_bus_in_n[7:0];
				if (memreg_mid_strobe)
					m_mem[11:8] = ~memory_data_bus_in_n[11:8];
				if (memreg_top_strobe)
					m_mem[15:12] = ~memory_data_bus_in_n[15:12];
				if (pc_strobe)
					m_pc = {aux_arith_result_reg[11:1], 1'b0};
				if (flags_strobe)
					m_flg = flags_from_aux ?
						{m_flg[2], aux_adder_sum == 12'h000, aux_adder_carry} :
						{byte_adder_sum[7], byte_adder_sum == 8'h00, byte_adder_carry};
			end
		end
	endtask : cyc

	task conclude;
		$display("Counts: %0d checks, %0d mismatches", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Run needs about 905 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(32'hc7a9));
		rst_n = 1'b0;
		cyc(1'b0, 1'b0);
		@(negedge clk);
		cyc(1'b0, 1'b0);
		@(negedge clk);
		rst_n = 1'b1;
		cyc(1'b0, 1'b1);
		$display("Test reset values done");
		repeat (600)
		begin
			@(negedge clk);
			cyc(1'b1, 1'b1);
		end
		$display("Test random traffic done");
		@(negedge clk);
		rst_n = 1'b0;
		cyc(1'b0, 1'b1);
		@(negedge clk);
		cyc(1'b0, 1'b1);
		@(negedge clk);
		rst_n = 1'b1;
		cyc(1'b0, 1'b1);
		repeat (300)
		begin
			@(negedge clk);
			cyc(1'b1, 1'b1);
		end
		$display("Test reset mid-run done");
		#10;
		conclude();
	end
endmodule : terminal_cpu_register_datapath_tb_top
